// [design/thl_head_link.sv]
// holds the link state control and the toggle-bit command handshake of the head
// assumes image bytes are synchronous to CLK_IN and the tag side answers reads
// within the cycle of the read strobe; the prefetch engine itself lies outside
`timescale 1ns/1ps
module thl_head_link
    import thl_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic [7:0]  CMD_BYTE0_IN,
    input  wire logic [31:0] CMD_ADDR_IN,
    input  wire logic [15:0] CMD_COUNT_IN,
    input  wire logic [7:0]  CMD_WDATA_IN,
    input  wire logic        ACYC_REQ_IN,
    input  wire logic        TAG_PRESENT_IN,
    input  wire logic        PREFETCH_DONE_IN,
    input  wire logic [7:0]  PREFETCH_DATA_IN,
    input  wire logic [7:0]  TAG_RDATA_IN,
    output logic [7:0]       RSP_BYTE0_OUT,
    output logic [7:0]       RSP_RESULT_OUT,
    output logic [7:0]       RSP_DATA_OUT,
    output logic [7:0]       EVT_DATA_OUT,
    output logic [7:0]       EVT_SPARE_OUT,
    output logic             EVT_STROBE_OUT,
    output logic             ACYC_REJECT_OUT,
    output logic             RF_FIELD_OUT,
    output logic [4:0]       LINK_STATE_OUT,
    output logic             PREFETCH_START_OUT,
    output logic             TAG_WR_OUT,
    output logic             TAG_RD_OUT,
    output logic [31:0]      TAG_ADDR_OUT,
    output logic [7:0]       TAG_WDATA_OUT
);
    // ====================================================================
    // declarations
    thl_link_e   link_q;
    thl_link_e   link_d;
    thl_cmd_e    cmd_q;
    logic [1:0]  auto_q;
    logic        new_cmd;
    logic [6:0]  code;
    logic        connected;

    function automatic logic is_cmd(input logic [6:0] c);
        is_cmd = new_cmd && (code == c);
    endfunction

    // a command is taken when the toggle differs from the last mirrored one
    assign new_cmd   = (cmd_q == CS_IDLE) && (CMD_BYTE0_IN[TBIT_POS] != RSP_BYTE0_OUT[TBIT_POS]);
    assign code      = CMD_BYTE0_IN[6:0];
    assign connected = (link_q == LK_CONNECTED);

    // ====================================================================
    // link state: next value
    always_comb begin
        link_d = link_q;
        case (link_q)
            LK_DISCONNECTED: begin
                if (is_cmd(CMD_CONNECT) || is_cmd(CMD_RECONNECT)) begin
                    link_d = LK_CONNECTING;
                end
            end
            LK_CONNECTING: begin
                if (is_cmd(CMD_DISCONNECT)) begin
                    link_d = LK_DISCONNECTED;
                end else if (TAG_PRESENT_IN) begin
                    link_d = LK_PREFETCH;
                end
            end
            LK_PREFETCH: begin
                // disconnect and reconnect commands are not acted on while the sequence runs
                if (PREFETCH_DONE_IN) begin
                    case (auto_q)
                        AUTO_RECONNECT:  link_d = LK_CONNECTING;
                        AUTO_DISCONNECT: link_d = LK_DISCONNECTED;
                        default:         link_d = LK_CONNECTED;
                    endcase
                end else if (!TAG_PRESENT_IN) begin
                    link_d = LK_CONNECTING;
                end
            end
            LK_CONNECTED: begin
                // sign-off commands win over a tag leaving in the same cycle
                if (is_cmd(CMD_DISCONNECT)) begin
                    link_d = LK_DISCONNECTED;
                end else if (is_cmd(CMD_RECONNECT)) begin
                    link_d = LK_CONNECTING;
                end else if (!TAG_PRESENT_IN) begin
                    link_d = LK_ERROR;
                end
            end
            LK_ERROR: begin
                // only an explicit command leaves error, so no tag signs on by itself
                if (is_cmd(CMD_DISCONNECT)) begin
                    link_d = LK_DISCONNECTED;
                end else if (is_cmd(CMD_RECONNECT)) begin
                    link_d = LK_CONNECTING;
                end
            end
            default: link_d = LK_DISCONNECTED;
        endcase
    end

    // link state register and its mirror
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            link_q         <= LK_DISCONNECTED;
            LINK_STATE_OUT <= LK_DISCONNECTED;
        end else begin
            link_q         <= link_d;
            LINK_STATE_OUT <= link_d;
        end
    end

    // rf field follows the next link state so it drops with the state change
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RF_FIELD_OUT <= 1'b0;
        end else begin
            RF_FIELD_OUT <= (link_d != LK_DISCONNECTED) && (link_d != LK_ERROR);
        end
    end

    // prefetch kick on entry to the prefetch phase
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            PREFETCH_START_OUT <= 1'b0;
        end else begin
            PREFETCH_START_OUT <= (link_q == LK_CONNECTING) && (link_d == LK_PREFETCH);
        end
    end

    // ====================================================================
    // event channel, separate from the reply image
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            EVT_DATA_OUT   <= BYTE_ZERO;
            EVT_SPARE_OUT  <= BYTE_ZERO;
            EVT_STROBE_OUT <= 1'b0;
        end else begin
            EVT_SPARE_OUT  <= BYTE_ZERO;
            EVT_STROBE_OUT <= (link_q == LK_PREFETCH) && PREFETCH_DONE_IN;
            if ((link_q == LK_PREFETCH) && PREFETCH_DONE_IN) begin
                EVT_DATA_OUT <= PREFETCH_DATA_IN;
            end
        end
    end

    // acyclic services are never served, each one is answered with a reject
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ACYC_REJECT_OUT <= 1'b0;
        end else begin
            ACYC_REJECT_OUT <= ACYC_REQ_IN;
        end
    end

    // auto operation setting
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            auto_q <= AUTO_OFF;
        end else if (is_cmd(CMD_AUTO_MODE)) begin
            auto_q <= CMD_ADDR_IN[25:24]; // first parameter byte, low bits
        end
    end

    // ====================================================================
    // tag access strobes; address arrives most significant byte first
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            TAG_WR_OUT    <= 1'b0;
            TAG_RD_OUT    <= 1'b0;
            TAG_ADDR_OUT  <= '0;
            TAG_WDATA_OUT <= BYTE_ZERO;
        end else begin
            TAG_WR_OUT <= is_cmd(CMD_WRITE) && connected && (CMD_COUNT_IN == ONE_BYTE_LEN);
            TAG_RD_OUT <= is_cmd(CMD_READ) && connected && (CMD_COUNT_IN == ONE_BYTE_LEN);
            if (new_cmd) begin
                TAG_ADDR_OUT  <= CMD_ADDR_IN;
                TAG_WDATA_OUT <= CMD_WDATA_IN;
            end
        end
    end

    // command handler: a read waits one cycle for tag data before replying
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cmd_q <= CS_IDLE;
        end else begin
            case (cmd_q)
                CS_IDLE: begin
                    if (is_cmd(CMD_READ) && connected && (CMD_COUNT_IN == ONE_BYTE_LEN)) begin
                        cmd_q <= CS_READ;
                    end
                end
                CS_READ: cmd_q <= CS_IDLE;
                default: cmd_q <= CS_IDLE;
            endcase
        end
    end

    // reply image; toggle mirrored only once the command has finished
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RSP_BYTE0_OUT  <= BYTE_ZERO;
            RSP_RESULT_OUT <= RES_OK;
            RSP_DATA_OUT   <= BYTE_ZERO;
        end else if (cmd_q == CS_READ) begin
            RSP_BYTE0_OUT  <= CMD_BYTE0_IN;
            RSP_RESULT_OUT <= RES_OK;
            RSP_DATA_OUT   <= TAG_RDATA_IN;
        end else if (new_cmd && !(is_cmd(CMD_READ) && connected && (CMD_COUNT_IN == ONE_BYTE_LEN))) begin
            RSP_BYTE0_OUT <= CMD_BYTE0_IN;
            RSP_DATA_OUT  <= BYTE_ZERO;
            case (code)
                CMD_IDLE, CMD_CONNECT, CMD_DISCONNECT, CMD_RECONNECT, CMD_AUTO_MODE:
                    RSP_RESULT_OUT <= RES_OK;
                CMD_WRITE, CMD_READ:
                    RSP_RESULT_OUT <= !connected ? RES_NOT_CONN :
                                      (CMD_COUNT_IN != ONE_BYTE_LEN) ? RES_BAD_LEN : RES_OK;
                default:
                    RSP_RESULT_OUT <= RES_BAD_CMD;
            endcase
        end
    end

    // ====================================================================
    // checks
    sequence s_lost_tag;
        connected && !TAG_PRESENT_IN && !new_cmd;
    endsequence

    sequence s_prefetch_done;
        (link_q == LK_PREFETCH) && PREFETCH_DONE_IN;
    endsequence

    a_lost_tag_error: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_lost_tag |=> (link_q == LK_ERROR) && !RF_FIELD_OUT)
        else $error("tag loss did not enter error");
    a_error_field_off: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        (link_q == LK_ERROR) |-> !RF_FIELD_OUT)
        else $error("field on in error state");
    a_auto_reconnect: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_prefetch_done and (auto_q == AUTO_RECONNECT) |=> (link_q == LK_CONNECTING) && RF_FIELD_OUT)
        else $error("auto reconnect did not keep field");
    a_auto_disconnect: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_prefetch_done and (auto_q == AUTO_DISCONNECT) |=> (link_q == LK_DISCONNECTED) && !RF_FIELD_OUT)
        else $error("auto disconnect did not drop field");
    a_auto_skip_conn: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        ((auto_q == AUTO_RECONNECT) || (auto_q == AUTO_DISCONNECT)) && (link_q == LK_PREFETCH)
        |=> (link_q != LK_CONNECTED))
        else $error("connected entered in auto mode");
    a_event_report: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_prefetch_done |=> EVT_STROBE_OUT && (EVT_DATA_OUT == $past(PREFETCH_DATA_IN)))
        else $error("prefetch data not reported");
    a_write_connected: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        TAG_WR_OUT |-> ($past(link_q) == LK_CONNECTED))
        else $error("tag write outside connected");
    a_toggle_mirror: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        new_cmd |-> ##[1:2] (RSP_BYTE0_OUT == $past(CMD_BYTE0_IN)))
        else $error("toggle not mirrored in time");
    a_acyc_reject: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        ACYC_REQ_IN |=> ACYC_REJECT_OUT)
        else $error("acyclic request not rejected");
    a_spare_zero: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        EVT_SPARE_OUT == BYTE_ZERO)
        else $error("unassigned event byte not zero");
    a_idle_nop: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        is_cmd(CMD_IDLE) && (link_q != LK_PREFETCH) && (link_q != LK_CONNECTED) && (link_q != LK_CONNECTING)
        |=> $stable(link_q) && (RSP_RESULT_OUT == RES_OK))
        else $error("idle command changed state");
endmodule

// [design/thl_pkg.sv]
// holds shared constants and types of the tag head link and command block
// assumes the fieldbus images are presented as parallel bytes each clock
package thl_pkg;
    // ====================================================================
    // link states, one-hot
    typedef enum logic [4:0] {
        LK_DISCONNECTED = 5'h01,
        LK_CONNECTING   = 5'h02,
        LK_PREFETCH     = 5'h04,
        LK_CONNECTED    = 5'h08,
        LK_ERROR        = 5'h10
    } thl_link_e;

    // command handler states, one-hot
    typedef enum logic [1:0] {
        CS_IDLE = 2'h1,
        CS_READ = 2'h2
    } thl_cmd_e;

    // ====================================================================
    // command codes (bits 6-0 of byte 0)
    localparam logic [6:0] CMD_IDLE       = 7'h00;
    localparam logic [6:0] CMD_WRITE      = 7'h20;
    localparam logic [6:0] CMD_READ       = 7'h21;
    localparam logic [6:0] CMD_CONNECT    = 7'h30;
    localparam logic [6:0] CMD_DISCONNECT = 7'h31;
    localparam logic [6:0] CMD_RECONNECT  = 7'h32;
    localparam logic [6:0] CMD_AUTO_MODE  = 7'h33;

    // auto operation setting, taken from the first parameter byte
    localparam logic [1:0] AUTO_OFF        = 2'h0;
    localparam logic [1:0] AUTO_RECONNECT  = 2'h1;
    localparam logic [1:0] AUTO_DISCONNECT = 2'h2;

    // result codes at input byte 1
    localparam logic [7:0] RES_OK       = 8'h00;
    localparam logic [7:0] RES_NOT_CONN = 8'h01;
    localparam logic [7:0] RES_BAD_CMD  = 8'h02;
    localparam logic [7:0] RES_BAD_LEN  = 8'h03;

    // field layout of byte 0 and constants
    localparam int         TBIT_POS      = 7;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [15:0] ONE_BYTE_LEN = 16'h0001;
endpackage

// [test/thl_master_model.sv]
// holds a behavioural model of the fieldbus master that owns the command image
// assumes the block mirrors output byte 0 into input byte 0 once a command is done
`timescale 1ns/1ps
module thl_master_model
    import thl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [7:0]  rsp_byte0_in,
    output logic [7:0]       cmd_byte0_out,
    output logic [31:0]      cmd_addr_out,
    output logic [15:0]      cmd_count_out,
    output logic [7:0]       cmd_wdata_out
);
    logic toggle_q;

    // ====================================================================
    // image starts all zero with toggle low, matching the mirror after reset
    initial begin
        toggle_q      = 1'b0;
        cmd_byte0_out = 8'h00;
        cmd_addr_out  = 32'h0000_0000;
        cmd_count_out = 16'h0000;
        cmd_wdata_out = 8'h00;
    end

    // ====================================================================
    // whole command and inverted toggle go out on one edge and then stand still,
    // so the block never sees a half-written command; gives up after 16 cycles
    task automatic command(input logic [6:0] code, input logic [31:0] addr, input logic [15:0] cnt,
                           input logic [7:0] wdata, output logic [7:0] sent);
        int n;
        n        = 0;
        toggle_q = ~toggle_q;
        sent     = {toggle_q, code};
        @(posedge clk_in);
        cmd_byte0_out <= sent;
        cmd_addr_out  <= addr;
        cmd_count_out <= cnt;
        cmd_wdata_out <= wdata;
        // hold everything until the mirror shows the new toggle
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (rsp_byte0_in !== sent && n < 16);
    endtask
endmodule

// [test/tb_top.sv]
// holds the self-checking bench of the head link and command handshake block
// assumes the master model drives the command image and the bench plays the tag
`timescale 1ns/1ps
module tb_top
    import thl_pkg::*;
;
    logic        clk, rstn, acyc, tag, pf_done;
    logic        evt_stb, acyc_rej, rf, pf_start, tag_wr, tag_rd;
    logic [7:0]  pf_data, tag_rdata, sent, cmd_b0, cmd_wd, tag_wdata;
    logic [7:0]  rsp_b0, rsp_res, rsp_data, evt_data, evt_spare;
    logic [31:0] cmd_addr, tag_addr;
    logic [15:0] cmd_cnt;
    logic [4:0]  link;
    int          fail_count, num_checks, cycles, wr_cnt, rd_cnt;

    thl_head_link u_thl_head_link (
        .CLK_IN(clk), .RSTN_IN(rstn), .CMD_BYTE0_IN(cmd_b0), .CMD_ADDR_IN(cmd_addr),
        .CMD_COUNT_IN(cmd_cnt), .CMD_WDATA_IN(cmd_wd), .ACYC_REQ_IN(acyc), .TAG_PRESENT_IN(tag),
        .PREFETCH_DONE_IN(pf_done), .PREFETCH_DATA_IN(pf_data), .TAG_RDATA_IN(tag_rdata),
        .RSP_BYTE0_OUT(rsp_b0), .RSP_RESULT_OUT(rsp_res), .RSP_DATA_OUT(rsp_data),
        .EVT_DATA_OUT(evt_data), .EVT_SPARE_OUT(evt_spare), .EVT_STROBE_OUT(evt_stb),
        .ACYC_REJECT_OUT(acyc_rej), .RF_FIELD_OUT(rf), .LINK_STATE_OUT(link),
        .PREFETCH_START_OUT(pf_start), .TAG_WR_OUT(tag_wr), .TAG_RD_OUT(tag_rd),
        .TAG_ADDR_OUT(tag_addr), .TAG_WDATA_OUT(tag_wdata));

    thl_master_model master (
        .clk_in(clk), .rsp_byte0_in(rsp_b0), .cmd_byte0_out(cmd_b0), .cmd_addr_out(cmd_addr),
        .cmd_count_out(cmd_cnt), .cmd_wdata_out(cmd_wd));

    // ====================================================================
    // clock and watchdog; the strobe counters catch pulses between checks
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (tag_wr === 1'b1) wr_cnt++;
        if (tag_rd === 1'b1) rd_cnt++;
        if (cycles == 4000) begin
            fail_count++;
            results();
        end
    end

    // ====================================================================
    // comparison, verdict and a command with its reply check
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmd(input logic [6:0] code, input logic [31:0] addr, input logic [15:0] cnt,
                       input logic [7:0] wd, input logic [7:0] exp_res);
        master.command(code, addr, cnt, wd, sent);
        chk(rsp_b0, sent);
        chk(rsp_res, exp_res);
    endtask
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // ====================================================================
    // scenarios
    task automatic t_reset_and_refused();
        chk(link, LK_DISCONNECTED);
        chk(rf, 1'b0);
        chk(evt_spare, 8'h00);
        cmd(CMD_WRITE, 32'h0000_0004, ONE_BYTE_LEN, 8'h11, RES_NOT_CONN);
        cmd(CMD_READ, 32'h0000_0004, ONE_BYTE_LEN, 8'h00, RES_NOT_CONN);
        cmd(CMD_IDLE, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        cmd(7'h7f, 32'h0000_0000, 16'h0000, 8'h00, RES_BAD_CMD);
        chk(link, LK_DISCONNECTED);
    endtask

    task automatic t_acyclic();
        @(posedge clk) acyc <= 1'b1;
        @(posedge clk) acyc <= 1'b0;
        #1;
        chk(acyc_rej, 1'b1);
        settle();
        chk(acyc_rej, 1'b0);
        chk(link, LK_DISCONNECTED);
    endtask

    // auto setting, connect, tag passes, prefetch ends; checks the end state
    task automatic t_pass(input logic [1:0] mode, input logic [4:0] exp_link, input logic exp_rf,
                          input logic keep_tag, input logic [7:0] data);
        cmd(CMD_AUTO_MODE, {6'h00, mode, 24'h00_0000}, 16'h0000, 8'h00, RES_OK);
        cmd(CMD_CONNECT, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        settle();
        chk(link, LK_CONNECTING);
        chk(rf, 1'b1);
        @(posedge clk) tag <= 1'b1;
        settle();
        chk(link, LK_PREFETCH);
        chk(pf_start, 1'b1);
        @(posedge clk) pf_done <= 1'b1;
        pf_data <= data;
        @(posedge clk) pf_done <= 1'b0;
        tag <= keep_tag;
        #1;
        chk(link, exp_link);
        chk(rf, exp_rf);
        chk(evt_stb, 1'b1);
        chk(evt_data, data);
        chk(evt_spare, 8'h00);
    endtask

    task automatic t_connected_access();
        chk(link, LK_CONNECTED);
        @(posedge clk) tag_rdata <= 8'h5a;
        cmd(CMD_WRITE, 32'h0001_0203, ONE_BYTE_LEN, 8'hc3, RES_OK);
        chk(tag_wr, 1'b1);
        chk(tag_addr, 32'h0001_0203);
        chk(tag_wdata, 8'hc3);
        cmd(CMD_READ, 32'h0000_0010, ONE_BYTE_LEN, 8'h00, RES_OK);
        chk(rsp_data, 8'h5a);
        cmd(CMD_WRITE, 32'h0000_0010, 16'h0100, 8'h00, RES_BAD_LEN);
        cmd(CMD_IDLE, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        chk(rsp_data, 8'h00);
        chk(link, LK_CONNECTED);
    endtask

    task automatic t_lifeguard();
        @(posedge clk) tag <= 1'b0;
        settle();
        chk(link, LK_ERROR);
        chk(rf, 1'b0);
        @(posedge clk) tag <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(link, LK_ERROR);
        chk(rf, 1'b0);
        // leave error by a reconnect with the field empty, then sign off
        @(posedge clk) tag <= 1'b0;
        cmd(CMD_RECONNECT, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        chk(link, LK_CONNECTING);
        chk(rf, 1'b1);
        cmd(CMD_DISCONNECT, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        chk(link, LK_DISCONNECTED);
    endtask

    // ====================================================================
    // main sequence: reset held for three cycles, then the scenarios in turn
    initial begin
        rstn = 1'b0;
        {acyc, tag, pf_done, pf_data, tag_rdata} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        settle();
        t_reset_and_refused();
        t_acyclic();
        t_pass(AUTO_OFF, LK_CONNECTED, 1'b1, 1'b1, 8'h3c);
        t_connected_access();
        t_lifeguard();
        t_pass(AUTO_RECONNECT, LK_CONNECTING, 1'b1, 1'b0, 8'ha5);
        cmd(CMD_WRITE, 32'h0000_0000, ONE_BYTE_LEN, 8'h00, RES_NOT_CONN);
        cmd(CMD_DISCONNECT, 32'h0000_0000, 16'h0000, 8'h00, RES_OK);
        t_pass(AUTO_DISCONNECT, LK_DISCONNECTED, 1'b0, 1'b0, 8'h96);
        settle();
        chk(wr_cnt, 1);
        chk(rd_cnt, 1);
        results();
    end
endmodule
